// ==== tmw_chan_out.sv ====
// One compare output channel: pin state and pin connection.
// Assumes events arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tmw_chan_out
  import tmw_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [1:0] mode, // Output mode field of this channel.
  input wire tmw_wave_type wave, // Waveform class of the mode.
  input wire tmw_chev_type ev, // Qualified counter events.
  output logic pin, // Output compare pin state.
  output logic connected // Pin overrides the port function.
);

  // ----------------------------------------------------------------
  // Connection
  // ----------------------------------------------------------------
  // toggle only where allowed
  always_comb begin
    connected = (mode != 2'h0) &&
                !(mode == 2'h1 && wave != WAVE_NONPWM && !ev.toggle_ok);
  end

  // ----------------------------------------------------------------
  // Pin state
  // ----------------------------------------------------------------
  // The pin register holds its value while disconnected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
    end else if (connected) begin
      case (wave)
        WAVE_NONPWM: begin
          if (ev.match) begin
            pin <= mode[1] ? mode[0] : ~pin;
          end
        end
        WAVE_FAST: begin
          if (ev.match && !mode[1]) begin
            pin <= ~pin;
          end else if (ev.bottom && mode[1]) begin
            pin <= ~mode[0];
          end else if (ev.match && !ev.ignore) begin
            pin <= mode[0];
          end
        end
        WAVE_DUAL: begin
          if (ev.match) begin
            pin <= !mode[1] ? ~pin : (ev.up ? mode[0] : ~mode[0]);
          end
        end
        default: begin
          pin <= pin;
        end
      endcase
    end
  end

endmodule : tmw_chan_out
`default_nettype wire

// ==== tmw_pkg.sv ====
// Shared constants and types for the 16-bit timer waveform mode and
// compare-output control block.
// Assumes a single APB clock domain and 8-bit byte addresses.
package tmw_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A = 8'h80;
  localparam logic [7:0] OFS_CTRL_B = 8'h84;
  localparam logic [7:0] OFS_DIV = 8'h88;
  localparam logic [7:0] OFS_CNT = 8'h8C;
  localparam logic [7:0] OFS_CMPA = 8'h90;
  localparam logic [7:0] OFS_CMPB = 8'h94;
  localparam logic [7:0] OFS_CAP = 8'h98;
  localparam logic [7:0] OFS_STAT = 8'h9C;
  localparam logic [7:0] OFS_MASK = 8'hA0;
  localparam logic [7:0] OFS_DIR = 8'hA4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CA_MODE_LSB = 6;
  localparam int CB_MODE_LSB = 4;
  localparam int WM_HIGH_LSB = 3;
  localparam int RUN_BIT = 0;
  localparam int ST_OVF = 0;
  localparam int ST_MA = 1;
  localparam int ST_MB = 2;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // ----------------------------------------------------------------
  // Mode decode types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TOP_FFFF, TOP_00FF, TOP_01FF, TOP_03FF, TOP_CMPA,
                            TOP_CAP} tmw_top_type;
  typedef enum logic [1:0] {WAVE_NONPWM, WAVE_FAST, WAVE_DUAL} tmw_wave_type;
  typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOTTOM} tmw_upd_type;
  typedef enum logic [1:0] {OVF_MAX, OVF_TOP, OVF_BOTTOM} tmw_ovf_type;

  typedef struct packed {
    tmw_top_type top;
    tmw_wave_type wave;
    tmw_upd_type upd;
    tmw_ovf_type ovf;
  } tmw_dec_type;

  // Per-channel events; match and bottom are already qualified by the timer clock enable.
  typedef struct packed {
    logic match;
    logic ignore;
    logic bottom;
    logic up;
    logic toggle_ok;
  } tmw_chev_type;

endpackage : tmw_pkg

// ==== tmw_timer.sv ====
// Top of the 16-bit timer waveform mode and compare-output control block.
// Assumes an APB master on pclk; pins are resolved outside from oe_n.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tmw_timer
  import tmw_pkg::*;
#(
  parameter int DIV_W = 16 // Width of the timer clock divider.
) (
  input wire logic pclk, // APB clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data, registered.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic irq, // Level interrupt.
  output logic chan_a_output_pin, // Channel A compare output.
  output logic chan_a_oe_n, // Channel A drive enable, active low.
  output logic chan_a_override, // Channel A owns the port pin.
  output logic chan_b_output_pin, // Channel B compare output.
  output logic chan_b_oe_n, // Channel B drive enable, active low.
  output logic chan_b_override // Channel B owns the port pin.
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_r;
  logic [1:0] waveform_mode_high_r;
  logic run_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic [15:0] counter_value_r;
  logic dir_up_r;
  logic blk_r;
  logic [15:0] cmp_buf_a_r;
  logic [15:0] cmp_buf_b_r;
  logic [15:0] compare_value_a_r;
  logic [15:0] compare_value_b_r;
  logic [15:0] capture_value_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [1:0] pin_dir_r;
  logic [3:0] waveform_mode;
  tmw_dec_type dec;
  logic [15:0] top_w;
  logic tick;
  logic wr_en;
  logic wr_cnt;
  logic at_top;
  logic at_bot;
  logic top_evt;
  logic bottom_evt;
  logic reload;
  logic ovf_evt;
  logic match_a;
  logic match_b;
  logic toggle_ok;
  logic mapped;
  logic [31:0] rd_nxt;
  logic [31:0] rd_nxt_r;
  tmw_chev_type ev_a;
  tmw_chev_type ev_b;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // four-bit mode decode
  assign waveform_mode = {waveform_mode_high_r, ctrl_a_r[1:0]};

  // Mode 13 is reserved and falls back to normal counting.
  always_comb begin
    dec = '{top: TOP_FFFF, wave: WAVE_NONPWM, upd: UPD_NOW, ovf: OVF_MAX};
    case (waveform_mode)
      4'h4: dec.top = TOP_CMPA;
      4'hC: dec.top = TOP_CAP;
      4'h1, 4'h2, 4'h3: begin
        dec = '{top: tmw_top_type'(waveform_mode[1:0]), wave: WAVE_DUAL,
                upd: UPD_TOP, ovf: OVF_BOTTOM};
      end
      4'h5, 4'h6, 4'h7: begin
        dec = '{top: tmw_top_type'(waveform_mode[1:0]), wave: WAVE_FAST,
                upd: UPD_BOTTOM, ovf: OVF_TOP};
      end
      4'hE, 4'hF: begin
        dec = '{top: waveform_mode[0] ? TOP_CMPA : TOP_CAP, wave: WAVE_FAST,
                upd: UPD_BOTTOM, ovf: OVF_TOP};
      end
      4'h8, 4'h9, 4'hA, 4'hB: begin
        dec = '{top: waveform_mode[0] ? TOP_CMPA : TOP_CAP, wave: WAVE_DUAL,
                upd: waveform_mode[1] ? UPD_TOP : UPD_BOTTOM, ovf: OVF_BOTTOM};
      end
      default: dec.top = TOP_FFFF;
    endcase
  end

  // TOP value from the decoded source.
  always_comb begin
    case (dec.top)
      TOP_00FF: top_w = TOP_8BIT;
      TOP_01FF: top_w = TOP_9BIT;
      TOP_03FF: top_w = TOP_10BIT;
      TOP_CMPA: top_w = compare_value_a_r;
      TOP_CAP: top_w = capture_value_r;
      default: top_w = TOP_MAX;
    endcase
  end

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  // one-cycle timer enable
  assign tick = run_r && (div_cnt_r == div_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= '0;
    end else if (tick || !run_r) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------
  assign at_top = (counter_value_r == top_w);
  assign at_bot = (counter_value_r == CNT_BOTTOM);
  assign top_evt = tick && at_top;
  assign bottom_evt = (dec.wave == WAVE_FAST) ? top_evt : (tick && at_bot && !dir_up_r);
  assign reload = (dec.upd == UPD_TOP) ? top_evt :
                  (dec.upd == UPD_BOTTOM) ? bottom_evt : 1'b0;
  assign match_a = tick && !blk_r && (counter_value_r == compare_value_a_r);
  assign match_b = tick && !blk_r && (counter_value_r == compare_value_b_r);
  assign toggle_ok = (waveform_mode == 4'hE) || (waveform_mode == 4'hF) ||
                     (waveform_mode == 4'h9) || (waveform_mode == 4'hB);

  always_comb begin
    case (dec.ovf)
      OVF_TOP: ovf_evt = top_evt;
      OVF_BOTTOM: ovf_evt = bottom_evt;
      default: ovf_evt = tick && (counter_value_r == TOP_MAX);
    endcase
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A software write wins over counting and blocks the next match.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_r <= CNT_BOTTOM;
      dir_up_r <= 1'b1;
    end else if (wr_cnt) begin
      counter_value_r <= pwdata[15:0];
    end else if (tick) begin
      if (dec.wave != WAVE_DUAL) begin
        dir_up_r <= 1'b1;
        counter_value_r <= at_top ? CNT_BOTTOM : counter_value_r + CNT_ONE;
      end else if (dir_up_r) begin
        dir_up_r <= (counter_value_r < top_w);
        counter_value_r <= (counter_value_r < top_w) ? counter_value_r + CNT_ONE :
                           counter_value_r - CNT_ONE;
      end else begin
        dir_up_r <= at_bot;
        counter_value_r <= at_bot ? CNT_ONE : counter_value_r - CNT_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_r <= 1'b0;
    end else if (wr_cnt) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Compare registers
  // ----------------------------------------------------------------
  // buffered reload at update point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_a_r <= CNT_BOTTOM;
      compare_value_b_r <= CNT_BOTTOM;
    end else if (dec.upd == UPD_NOW) begin
      compare_value_a_r <= cmp_buf_a_r;
      compare_value_b_r <= cmp_buf_b_r;
    end else if (reload) begin
      compare_value_a_r <= cmp_buf_a_r;
      compare_value_b_r <= cmp_buf_b_r;
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite && mapped;
  assign wr_cnt = wr_en && (paddr == OFS_CNT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rd_nxt_r;

  always_comb begin
    case (paddr)
      OFS_CTRL_A, OFS_CTRL_B, OFS_DIV, OFS_CNT, OFS_CMPA, OFS_CMPB, OFS_CAP,
      OFS_STAT, OFS_MASK, OFS_DIR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Control and configuration writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= CTRL_RST;
      waveform_mode_high_r <= CTRL_RST[1:0];
      run_r <= 1'b0;
      div_r <= '0;
      cmp_buf_a_r <= CNT_BOTTOM;
      cmp_buf_b_r <= CNT_BOTTOM;
      capture_value_r <= CNT_BOTTOM;
      mask_r <= FLAG_RST;
      pin_dir_r <= DIR_RST;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL_A: ctrl_a_r <= pwdata[7:0] & CTRL_A_WMASK;
        OFS_CTRL_B: begin
          waveform_mode_high_r <= pwdata[WM_HIGH_LSB+:2];
          run_r <= pwdata[RUN_BIT];
        end
        OFS_DIV: div_r <= pwdata[DIV_W-1:0];
        OFS_CMPA: cmp_buf_a_r <= pwdata[15:0];
        OFS_CMPB: cmp_buf_b_r <= pwdata[15:0];
        OFS_CAP: capture_value_r <= pwdata[15:0];
        OFS_MASK: mask_r <= pwdata[2:0];
        OFS_DIR: pin_dir_r <= pwdata[1:0];
        default: run_r <= run_r;
      endcase
    end
  end

  // Sticky flags; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= FLAG_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == ST_OVF && ovf_evt) || (i == ST_MA && match_a) ||
            (i == ST_MB && match_b)) begin
          stat_r[i] <= 1'b1;
        end else if (wr_en && paddr == OFS_STAT && pwdata[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // Read data is captured in the setup phase and held for the access.
  always_comb begin
    case (paddr)
      OFS_CTRL_A: rd_nxt = {24'h000000, ctrl_a_r};
      OFS_CTRL_B: rd_nxt = {27'h0000000, waveform_mode_high_r, 2'h0, run_r};
      OFS_DIV: rd_nxt = 32'(div_r);
      OFS_CNT: rd_nxt = {16'h0000, counter_value_r};
      OFS_CMPA: rd_nxt = {16'h0000, cmp_buf_a_r};
      OFS_CMPB: rd_nxt = {16'h0000, cmp_buf_b_r};
      OFS_CAP: rd_nxt = {16'h0000, capture_value_r};
      OFS_STAT: rd_nxt = {29'h00000000, stat_r};
      OFS_MASK: rd_nxt = {29'h00000000, mask_r};
      OFS_DIR: rd_nxt = {30'h00000000, pin_dir_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Read data register, loaded in the setup phase of a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_nxt_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      rd_nxt_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output channels
  // ----------------------------------------------------------------
  assign ev_a = '{match: match_a, ignore: mo_ignore(compare_value_a_r),
                  bottom: bottom_evt, up: dir_up_r, toggle_ok: toggle_ok};
  assign ev_b = '{match: match_b, ignore: mo_ignore(compare_value_b_r),
                  bottom: bottom_evt, up: dir_up_r, toggle_ok: 1'b0};

  function automatic logic mo_ignore(input logic [15:0] cmp);
    mo_ignore = (dec.wave == WAVE_FAST) && (cmp == top_w);
  endfunction : mo_ignore

  tmw_chan_out u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .mode(ctrl_a_r[CA_MODE_LSB+:2]),
    .wave(dec.wave),
    .ev(ev_a),
    .pin(chan_a_output_pin),
    .connected(chan_a_override)
  );

  tmw_chan_out u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .mode(ctrl_a_r[CB_MODE_LSB+:2]),
    .wave(dec.wave),
    .ev(ev_b),
    .pin(chan_b_output_pin),
    .connected(chan_b_override)
  );

  assign chan_a_oe_n = !(chan_a_override && pin_dir_r[0]);
  assign chan_b_oe_n = !(chan_b_override && pin_dir_r[1]);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tick_gates_count: assert property (
    !tick && !wr_cnt |=> $stable(counter_value_r))
    else $error("Counter moved without a timer tick.");
  a_pfc_reload_bottom: assert property (
    dec.upd == UPD_BOTTOM && dec.wave == WAVE_DUAL && tick && at_top && dir_up_r
    && !at_bot ##1 dec.upd == UPD_BOTTOM |-> $stable(compare_value_a_r))
    else $error("Frequency-correct compare reloaded at TOP.");
  a_field_zero_off: assert property (
    ctrl_a_r[CA_MODE_LSB+:2] == 2'h0 |-> !chan_a_override && chan_a_oe_n)
    else $error("Channel A connected with a zero field.");
  a_dir_gates_drive: assert property (
    !pin_dir_r[1] |-> chan_b_oe_n)
    else $error("Channel B driven without direction bit.");
  a_nonpwm_clear: assert property (
    dec.wave == WAVE_NONPWM && ctrl_a_r[CA_MODE_LSB+:2] == 2'h2 && match_a
    |=> !chan_a_output_pin)
    else $error("Non-PWM clear on match failed.");
  a_fast_b_toggle: assert property (
    dec.wave == WAVE_FAST && ctrl_a_r[CB_MODE_LSB+:2] == 2'h1 |-> !chan_b_override)
    else $error("Channel B connected in fast PWM toggle.");
  a_fast_bottom_set: assert property (
    dec.wave == WAVE_FAST && ctrl_a_r[CA_MODE_LSB+:2] == 2'h2 && bottom_evt
    |=> chan_a_output_pin)
    else $error("Fast PWM did not set at BOTTOM.");
  a_dual_down_set: assert property (
    dec.wave == WAVE_DUAL && ctrl_a_r[CA_MODE_LSB+:2] == 2'h2 && match_a
    && !dir_up_r |=> chan_a_output_pin)
    else $error("Dual slope did not set on down match.");
  a_dual_turn: assert property (
    dec.wave == WAVE_DUAL && tick && !wr_cnt && dir_up_r && at_top && !at_bot
    |=> !dir_up_r && counter_value_r == $past(counter_value_r) - CNT_ONE)
    else $error("Dual slope did not turn at TOP.");
  a_fast_ovf_top: assert property (
    dec.wave == WAVE_FAST && top_evt |=> stat_r[ST_OVF])
    else $error("Fast PWM overflow not set at TOP.");
  a_reserved_zero: assert property (
    ctrl_a_r[3:2] == 2'h0 ##1 ctrl_a_r[3:2] == 2'h0)
    else $error("Reserved control bits not zero.");

  c_fast_bottom: cover property (dec.wave == WAVE_FAST && bottom_evt);
  c_dual_turn: cover property (dec.wave == WAVE_DUAL && top_evt ##1 !dir_up_r);
  c_irq_rise: cover property (!irq ##1 irq);
  c_normal_ovf: cover property (dec.ovf == OVF_MAX && ovf_evt);

endmodule : tmw_timer
`default_nettype wire

// ==== tmw_timer_tb.sv ====
// Self-checking testbench for the timer waveform mode and output block.
// Assumes the package and design files are compiled first; APB is driven here.
`timescale 1ns/1ps
`default_nettype none
module tmw_timer_tb;
  import tmw_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, pa, pao, pov, pb, pbo, pbv, err;
  int mismatches = 0;
  int tests_run = 0;
  int n;

  // The clock toggles every half period of 5 ns.
  always #5 pclk = ~pclk;

  tmw_timer #(.DIV_W(16)) i_tmw_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .chan_a_output_pin(pa),
    .chan_a_oe_n(pao), .chan_a_override(pov), .chan_b_output_pin(pb),
    .chan_b_oe_n(pbo), .chan_b_override(pbv));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task give_verdict;
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(nm, rd, exp);
  endtask : rdc

  function automatic logic pin(input bit b);
    return b ? pb : pa;
  endfunction : pin

  // Counts cycles while a pin stays at one level, with a bound.
  task hold(input bit b, input logic lvl);
    n = 0;
    while (pin(b) === lvl) begin
      @(posedge pclk);
      n++;
      if (n > 4000) begin
        mismatches++;
        give_verdict();
      end
    end
  endtask : hold

  // Skips two periods, the first possibly partial, so that stale compare values settle first.
  task phase(input bit b, input logic lvl);
    repeat (2) begin
      hold(b, lvl);
      hold(b, !lvl);
    end
    hold(b, lvl);
  endtask : phase

  task setup(input logic [3:0] m, input logic [3:0] com, input logic [15:0] ca,
             input logic [15:0] cb, input logic [15:0] cap, input logic [15:0] dv);
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_DIV, 32'(dv));
    wr(OFS_CNT, 32'h0);
    wr(OFS_CMPA, 32'(ca));
    wr(OFS_CMPB, 32'(cb));
    wr(OFS_CAP, 32'(cap));
    wr(OFS_DIR, 32'h3);
    wr(OFS_CTRL_A, 32'({com, 2'b00, m[1:0]}));
    wr(OFS_CTRL_B, 32'({m[3:2], 3'b001}));
  endtask : setup

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_regs;
    rdc("ctrl_a_rst", OFS_CTRL_A, 32'h0);
    rdc("stat_rst", OFS_STAT, 32'h0);
    chk("oe_a_rst", pao, 1'b1);
    wr(OFS_CTRL_A, 32'hFF);
    rdc("ctrl_a_rw", OFS_CTRL_A, 32'hF3);
    apb(1'b0, 8'hFC, 32'h0);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0);
  endtask : t_regs

  task t_decode;
    logic tg, np, ea, eb;
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 16; m++) begin
        if (m != 13) begin
          np = (m == 0 || m == 4 || m == 12);
          tg = np || m == 9 || m == 11 || m == 14 || m == 15;
          ea = c[1] || (c == 1 && tg);
          eb = c[1] || (c == 1 && np);
          wr(OFS_DIR, 32'h1);
          wr(OFS_CTRL_A, 32'({c[1:0], c[1:0], 2'b00, m[1:0]}));
          wr(OFS_CTRL_B, 32'({m[3:2], 3'b000}));
          chk("ovr_a", pov, ea);
          chk("ovr_b", pbv, eb);
          chk("oe_a", pao, !ea);
          chk("oe_b", pbo, 1'b1);
        end
      end
    end
  endtask : t_decode

  task t_ctc;
    logic [3:0] m;
    // clear on match with toggle, set and clear.
    for (int i = 0; i < 4; i++) begin
      m = i[1] ? 4'd12 : 4'd4;
      setup(m, 4'b0111, 16'd5, 16'd3, 16'd5, 16'(i[0]));
      phase(1'b0, 1'b1);
      chk("ctc_toggle", n, 6 * (i[0] + 1));
      chk("set_b", pb, 1'b1);
      wr(OFS_CTRL_A, 32'({4'b0110, 2'b00, m[1:0]}));
      repeat (20) @(posedge pclk);
      chk("clear_b", pb, 1'b0);
    end
  endtask : t_ctc

  task t_fast;
    int top, k;
    // fast PWM duty for fixed tops.
    for (int i = 0; i < 3; i++) begin
      top = (256 << i) - 1;
      setup(4'(5 + i), 4'b1011, 16'd100, 16'd40, 16'h0, 16'h0);
      phase(1'b0, 1'b1);
      chk("fast_hi_a", n, 101);
      phase(1'b0, 1'b0);
      chk("fast_lo_a", n, top - 100);
      phase(1'b1, 1'b0);
      chk("fast_lo_b", n, 41);
    end
    // compare at top leaves the pin set.
    setup(4'd5, 4'b1000, 16'h00FF, 16'h0, 16'h0, 16'h0);
    repeat (600) @(posedge pclk);
    k = 0;
    repeat (300) begin
      @(posedge pclk);
      if (pa !== 1'b1) k++;
    end
    chk("top_ignored", k, 0);
  endtask : t_fast

  task t_dual;
    int top;
    // dual slope duty for fixed tops.
    for (int i = 0; i < 3; i++) begin
      top = (256 << i) - 1;
      setup(4'(1 + i), 4'b1000, 16'd100, 16'h0, 16'h0, 16'h0);
      phase(1'b0, 1'b0);
      chk("dual_lo", n, 2 * (top - 100));
      phase(1'b0, 1'b1);
      chk("dual_hi", n, 200);
    end
    // toggle on channel A with compare A as top.
    for (int i = 0; i < 2; i++) begin
      setup(i[0] ? 4'd11 : 4'd9, 4'b0101, 16'd10, 16'h0, 16'h0, 16'h0);
      phase(1'b0, 1'b1);
      chk("dual_toggle", n, 20);
    end
  endtask : t_dual

  task t_irq;
    setup(4'd5, 4'b0000, 16'd100, 16'd40, 16'h0, 16'h0);
    wr(OFS_MASK, 32'h0);
    repeat (300) @(posedge pclk);
    chk("irq_masked", irq, 1'b0);
    rdc("stat_set", OFS_STAT, 32'h7);
    wr(OFS_MASK, 32'h1);
    chk("irq_on", irq, 1'b1);
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_STAT, 32'h1);
    chk("irq_off", irq, 1'b0);
    rdc("stat_w1c", OFS_STAT, 32'h6);
  endtask : t_irq

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_decode();
    t_ctc();
    t_fast();
    t_dual();
    t_irq();
    give_verdict();
  end
endmodule : tmw_timer_tb
`default_nettype wire
